// ---- rtl/quasi_bidir_ports_one_two.sv ----
// two quasi-bidirectional ports with alternate functions and external address drive
// What this block does
// - first port resets all ones, weak pullup
// - second port resets high, weak pullup
// - written zero holds strong pulldown until one
// - zero-to-one write pulses strong high driver
// - weakly held bit acts as input
// - bits 0,1 carry timer two pins
// - bits 2,3 carry second serial port
// - bit4 rising, bit5 falling interrupt detect
// - bit6 rising, bit7 falling interrupt detect
// - second port drives upper address byte
// - page mode one: both address bytes
// - page mode two: upper address and data
// - address strobe latches low byte, in any mode
module quasi_bidir_ports_one_two (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // software writes to the port latches
  input wire logic i_first_port_wr,
  input wire logic [quasi_ports_pkg::PORT_W-1:0] i_first_port_wdata,
  input wire logic i_second_port_wr,
  input wire logic [quasi_ports_pkg::PORT_W-1:0] i_second_port_wdata,
  // pins
  input wire logic [quasi_ports_pkg::PORT_W-1:0] i_first_port_pins,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_first_port_pins_o,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_first_port_pins_oe,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_first_port_weak_pu,
  input wire logic [quasi_ports_pkg::PORT_W-1:0] i_second_port_pins,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_second_port_pins_o,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_second_port_pins_oe,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_second_port_weak_pu,
  // readback to the core
  output logic [quasi_ports_pkg::PORT_W-1:0] o_first_port_rd,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_second_port_rd,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_first_port_latch,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_second_port_latch,
  // timer two
  input wire logic i_timer_two_ext_io_en,
  input wire logic i_timer_two_ext_io_out,
  output logic o_timer_two_ext_io_in,
  output logic o_timer_two_capture_trigger,
  // second serial port
  input wire logic i_second_serial_tx_en,
  input wire logic i_second_serial_transmit,
  output logic o_second_serial_receive,
  // external interrupts
  output logic o_ext_irq_rise_a,
  output logic o_ext_irq_fall_a,
  output logic o_ext_irq_rise_b,
  output logic o_ext_irq_fall_b,
  // external memory interface
  input wire quasi_ports_pkg::ext_bus_s i_ext_bus,
  output logic [quasi_ports_pkg::PORT_W-1:0] o_ext_rdata,
  output logic o_ale
);

  // pin levels reach this logic only through the two-flop synchroniser in
  // each cell, so the port readback lags the pin by two cycles, and the interrupt strobes
  // and the timer and serial inputs by a third; latency is traded for clean edges on slow,
  // unrelated board signals
  //
  // synchronised pin levels seen through the cells
  logic [quasi_ports_pkg::PORT_W-1:0] p1_sync;
  logic [quasi_ports_pkg::PORT_W-1:0] p2_sync;

  // ownership and value of each first-port pin by the on-chip functions
  logic [quasi_ports_pkg::PORT_W-1:0] p1_alt_en;
  logic [quasi_ports_pkg::PORT_W-1:0] p1_alt_val;

  // the second port is owned bytewise by the external bus
  logic [quasi_ports_pkg::PORT_W-1:0] p2_alt_en;
  logic [quasi_ports_pkg::PORT_W-1:0] p2_alt_val;
  logic [quasi_ports_pkg::PORT_W-1:0] bus_byte_now;
  logic bus_read_now;

  // all registered state of this level
  quasi_ports_pkg::top_state_s q;
  quasi_ports_pkg::top_state_s d;

  // one edge detector, shared by the four interrupt inputs
  function automatic logic edge_seen(
    input logic now_lvl,
    input logic was_lvl,
    input logic rising
  );
    logic hit;
    if (rising) begin
      hit = now_lvl & ~was_lvl;
    end else begin
      hit = ~now_lvl & was_lvl;
    end
    return hit;
  endfunction

  // byte that the second port shows during an external access
  function automatic logic [quasi_ports_pkg::PORT_W-1:0] bus_byte(
    input quasi_ports_pkg::ext_bus_s b
  );
    logic [quasi_ports_pkg::PORT_W-1:0] hi;
    logic [quasi_ports_pkg::PORT_W-1:0] lo;
    logic [quasi_ports_pkg::PORT_W-1:0] pick;
    hi = b.addr[quasi_ports_pkg::ADDR_HI_LSB +: quasi_ports_pkg::PORT_W];
    lo = b.addr[quasi_ports_pkg::ADDR_LO_LSB +: quasi_ports_pkg::PORT_W];
    pick = hi;
    unique case (b.mode)
      quasi_ports_pkg::MODE_TRAD: begin
        pick = hi;
      end
      quasi_ports_pkg::MODE_PAGE_ONE: begin
        // address phase carries the high byte, the other phase the low byte
        pick = b.addr_phase ? hi : lo;
      end
      quasi_ports_pkg::MODE_PAGE_TWO: begin
        if (b.addr_phase) begin
          pick = hi;
        end else if (b.write) begin
          pick = b.wdata;
        end else begin
          // released so the addressed device can drive the read byte
          pick = quasi_ports_pkg::RELEASE_ALL;
        end
      end
      default: begin
        // the fourth code names no mode; keep the plain address drive
        pick = hi;
      end
    endcase
    return pick;
  endfunction

  // true while a paged read expects data back on the second port
  function automatic logic bus_reads(input quasi_ports_pkg::ext_bus_s b);
    return b.cycle & ~b.write & ~b.addr_phase & (b.mode == quasi_ports_pkg::MODE_PAGE_TWO);
  endfunction

  // first-port pins that an on-chip function may drive
  for (genvar b = 0; b < quasi_ports_pkg::PORT_W; b++) begin : g_p1_alt
    if (b == quasi_ports_pkg::BIT_TIMER_IO) begin : g_timer
      assign p1_alt_en[b] = i_timer_two_ext_io_en;
      assign p1_alt_val[b] = i_timer_two_ext_io_out;
    end else if (b == quasi_ports_pkg::BIT_SER_TX) begin : g_ser_tx
      assign p1_alt_en[b] = i_second_serial_tx_en;
      assign p1_alt_val[b] = i_second_serial_transmit;
    end else begin : g_input_only
      // inputs and interrupt pins are never driven by a function
      assign p1_alt_en[b] = 1'h0;
      assign p1_alt_val[b] = 1'h1;
    end
  end

  // the external bus owns every second-port pin for the length of a cycle;
  // a latch bit left at zero still wins, so software must keep it at one
  assign bus_byte_now = bus_byte(i_ext_bus);
  assign bus_read_now = bus_reads(i_ext_bus);
  for (genvar b = 0; b < quasi_ports_pkg::PORT_W; b++) begin : g_p2_alt
    assign p2_alt_en[b] = i_ext_bus.cycle;
    assign p2_alt_val[b] = bus_byte_now[b];
  end

  // first port cells; each resets to latch one on the weak pullup
  for (genvar b = 0; b < quasi_ports_pkg::PORT_W; b++) begin : g_p1_cell
    quasi_pin_cell u_cell (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_latch_wr(i_first_port_wr),
      .i_latch_val(i_first_port_wdata[b]),
      .i_alt_en(p1_alt_en[b]),
      .i_alt_val(p1_alt_val[b]),
      .i_pin(i_first_port_pins[b]),
      .o_pin_o(o_first_port_pins_o[b]),
      .o_pin_oe(o_first_port_pins_oe[b]),
      .o_weak_pu(o_first_port_weak_pu[b]),
      .o_pin_sync(p1_sync[b]),
      .o_latch(o_first_port_latch[b])
    );
  end

  // second port cells; same reset to high on the weak pullup
  for (genvar b = 0; b < quasi_ports_pkg::PORT_W; b++) begin : g_p2_cell
    quasi_pin_cell u_cell (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_latch_wr(i_second_port_wr),
      .i_latch_val(i_second_port_wdata[b]),
      .i_alt_en(p2_alt_en[b]),
      .i_alt_val(p2_alt_val[b]),
      .i_pin(i_second_port_pins[b]),
      .o_pin_o(o_second_port_pins_o[b]),
      .o_pin_oe(o_second_port_pins_oe[b]),
      .o_weak_pu(o_second_port_weak_pu[b]),
      .o_pin_sync(p2_sync[b]),
      .o_latch(o_second_port_latch[b])
    );
  end

  // next state: interrupt edges, alternate inputs, strobe and read capture
  always_comb begin
    d = q;
    d.prev_p1 = p1_sync;
    d.irq_rise_a = edge_seen(p1_sync[quasi_ports_pkg::BIT_IRQ_RISE_A],
      q.prev_p1[quasi_ports_pkg::BIT_IRQ_RISE_A], 1'h1);
    d.irq_fall_a = edge_seen(p1_sync[quasi_ports_pkg::BIT_IRQ_FALL_A],
      q.prev_p1[quasi_ports_pkg::BIT_IRQ_FALL_A], 1'h0);
    d.irq_rise_b = edge_seen(p1_sync[quasi_ports_pkg::BIT_IRQ_RISE_B],
      q.prev_p1[quasi_ports_pkg::BIT_IRQ_RISE_B], 1'h1);
    d.irq_fall_b = edge_seen(p1_sync[quasi_ports_pkg::BIT_IRQ_FALL_B],
      q.prev_p1[quasi_ports_pkg::BIT_IRQ_FALL_B], 1'h0);
    // timer and serial inputs pass on the synchronised level
    d.timer_io = p1_sync[quasi_ports_pkg::BIT_TIMER_IO];
    d.timer_trig = p1_sync[quasi_ports_pkg::BIT_TIMER_TRIG];
    d.ser_rx = p1_sync[quasi_ports_pkg::BIT_SER_RX];
    // strobe lets outside logic latch the low byte of the address
    d.ale = i_ext_bus.cycle & i_ext_bus.addr_strobe;
    // the synchroniser adds two cycles, so a read phase must outlast that
    if (bus_read_now) begin
      d.rdata = p2_sync;
    end
  end

  // idle pins are high, so the edge history starts high: no false edge after reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q.prev_p1 <= quasi_ports_pkg::PORT_RESET;
      q.irq_rise_a <= 1'h0;
      q.irq_fall_a <= 1'h0;
      q.irq_rise_b <= 1'h0;
      q.irq_fall_b <= 1'h0;
      q.timer_io <= 1'h1;
      q.timer_trig <= 1'h1;
      q.ser_rx <= 1'h1;
      q.ale <= 1'h0;
      q.rdata <= quasi_ports_pkg::PORT_NONE;
    end else begin
      q <= d;
    end
  end

  // every output comes from a register here or in a pin cell
  assign o_first_port_rd = p1_sync;
  assign o_second_port_rd = p2_sync;
  assign o_timer_two_ext_io_in = q.timer_io;
  assign o_timer_two_capture_trigger = q.timer_trig;
  assign o_second_serial_receive = q.ser_rx;
  assign o_ext_irq_rise_a = q.irq_rise_a;
  assign o_ext_irq_fall_a = q.irq_fall_a;
  assign o_ext_irq_rise_b = q.irq_rise_b;
  assign o_ext_irq_fall_b = q.irq_fall_b;
  assign o_ext_rdata = q.rdata;
  assign o_ale = q.ale;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // rising strobe only after a low-to-high step of the history
  rise_a_edge_a: assert property (
    q.irq_rise_a |-> q.prev_p1[quasi_ports_pkg::BIT_IRQ_RISE_A]
      && !$past(q.prev_p1[quasi_ports_pkg::BIT_IRQ_RISE_A]))
    else $error("rising interrupt strobe without a rising pin");

  // falling strobe only after a high-to-low step
  fall_a_edge_a: assert property (
    q.irq_fall_a |-> !q.prev_p1[quasi_ports_pkg::BIT_IRQ_FALL_A]
      && $past(q.prev_p1[quasi_ports_pkg::BIT_IRQ_FALL_A]))
    else $error("falling interrupt strobe without a falling pin");

  // second rising input behaves like the first
  rise_b_edge_a: assert property (
    q.irq_rise_b |-> q.prev_p1[quasi_ports_pkg::BIT_IRQ_RISE_B]
      && !$past(q.prev_p1[quasi_ports_pkg::BIT_IRQ_RISE_B]))
    else $error("rising interrupt strobe without a rising pin");

  // second falling input behaves like the first
  fall_b_edge_a: assert property (
    q.irq_fall_b |-> !q.prev_p1[quasi_ports_pkg::BIT_IRQ_FALL_B]
      && $past(q.prev_p1[quasi_ports_pkg::BIT_IRQ_FALL_B]))
    else $error("falling interrupt strobe without a falling pin");

  // serial receive follows its synchronised pin level one cycle later
  rx_follow_a: assert property (
    q.ser_rx == $past(p1_sync[quasi_ports_pkg::BIT_SER_RX]))
    else $error("serial receive input does not follow its pin");

  // capture trigger follows its synchronised pin level one cycle later
  trig_follow_a: assert property (
    q.timer_trig == $past(p1_sync[quasi_ports_pkg::BIT_TIMER_TRIG]))
    else $error("timer trigger input does not follow its pin");

  // strobe mirrors the bus request one cycle later
  ale_strobe_a: assert property (
    q.ale == $past(i_ext_bus.cycle && i_ext_bus.addr_strobe))
    else $error("address strobe out of step with the bus cycle");

  // read byte is held outside a read phase
  rdata_hold_a: assert property (
    !bus_read_now |=> q.rdata == $past(q.rdata))
    else $error("read byte changed outside a read phase");

  // main scenarios worth seeing at least once
  rise_seen_c: cover property (q.irq_rise_a);
  fall_seen_c: cover property (q.irq_fall_b);
  strobe_seen_c: cover property (q.ale);
  read_seen_c: cover property (bus_read_now ##1 bus_read_now);
  page_one_c: cover property (i_ext_bus.cycle
    && i_ext_bus.mode == quasi_ports_pkg::MODE_PAGE_ONE);

endmodule

// ---- rtl/quasi_ports_pkg.sv ----
// shared constants, modes and carrier structs for the two quasi-bidirectional ports
package quasi_ports_pkg;

  // port geometry
  localparam int PORT_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [PORT_W-1:0] PORT_RESET = 8'hff;
  localparam logic [PORT_W-1:0] PORT_NONE = 8'h00;
  localparam logic [PORT_W-1:0] RELEASE_ALL = 8'hff;

  // first port alternate function bit positions
  localparam int BIT_TIMER_IO = 0;
  localparam int BIT_TIMER_TRIG = 1;
  localparam int BIT_SER_RX = 2;
  localparam int BIT_SER_TX = 3;
  localparam int BIT_IRQ_RISE_A = 4;
  localparam int BIT_IRQ_FALL_A = 5;
  localparam int BIT_IRQ_RISE_B = 6;
  localparam int BIT_IRQ_FALL_B = 7;

  // external address byte positions
  localparam int ADDR_HI_LSB = 8;
  localparam int ADDR_LO_LSB = 0;

  // strong pull-high pulse after a zero-to-one write
  localparam int CLK_PERIOD_NS = 40;
  localparam int STRONG_PULSE_NS = 80;
  localparam int PULSE_CYCLES = (STRONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;

  // external memory interface modes
  typedef enum logic [1:0] {
    MODE_TRAD = 2'h0,
    MODE_PAGE_ONE = 2'h1,
    MODE_PAGE_TWO = 2'h2
  } page_mode_e;

  // one external bus request from the core
  typedef struct packed {
    logic cycle;
    page_mode_e mode;
    logic addr_phase;
    logic write;
    logic addr_strobe;
    logic [ADDR_W-1:0] addr;
    logic [PORT_W-1:0] wdata;
  } ext_bus_s;

  // state of one pin cell
  typedef struct packed {
    logic latch;
    logic eff;
    logic [CNT_W-1:0] pulse_cnt;
    logic pin_o;
    logic pin_oe;
    logic weak_pu;
    logic sync_a;
    logic sync_b;
  } cell_state_s;

  // state of the port top
  typedef struct packed {
    logic [PORT_W-1:0] prev_p1;
    logic irq_rise_a;
    logic irq_fall_a;
    logic irq_rise_b;
    logic irq_fall_b;
    logic timer_io;
    logic timer_trig;
    logic ser_rx;
    logic ale;
    logic [PORT_W-1:0] rdata;
  } top_state_s;

endpackage

// ---- rtl/quasi_pin_cell.sv ----
// one quasi-bidirectional pin: latch, drive sequencing and input synchroniser
module quasi_pin_cell (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_latch_wr,
  input wire logic i_latch_val,
  input wire logic i_alt_en,
  input wire logic i_alt_val,
  input wire logic i_pin,
  output logic o_pin_o,
  output logic o_pin_oe,
  output logic o_weak_pu,
  output logic o_pin_sync,
  output logic o_latch
);

  quasi_ports_pkg::cell_state_s q;
  quasi_ports_pkg::cell_state_s d;

  // next state: latch, effective level, drive phase
  always_comb begin
    d = q;
    if (i_latch_wr) begin
      d.latch = i_latch_val;
    end
    // function owns pin only while latch stays one
    d.eff = d.latch & (~i_alt_en | i_alt_val);
    d.sync_a = i_pin;
    d.sync_b = q.sync_a;
    if (!d.eff) begin
      d.pin_o = 1'h0;
      d.pin_oe = 1'h1;
      d.weak_pu = 1'h0;
      d.pulse_cnt = quasi_ports_pkg::CNT_ZERO;
    end else if (!q.eff) begin
      d.pin_o = 1'h1;
      d.pin_oe = 1'h1;
      d.weak_pu = 1'h1;
      d.pulse_cnt = quasi_ports_pkg::PULSE_LAST;
    end else if (q.pulse_cnt != quasi_ports_pkg::CNT_ZERO) begin
      d.pin_o = 1'h1;
      d.pin_oe = 1'h1;
      d.weak_pu = 1'h1;
      d.pulse_cnt = q.pulse_cnt - quasi_ports_pkg::CNT_ONE;
    end else begin
      // strong driver off so outside logic may pull low
      d.pin_o = 1'h1;
      d.pin_oe = 1'h0;
      d.weak_pu = 1'h1;
    end
  end

  // reset leaves pin high on the weak pullup only
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '{latch: 1'h1, eff: 1'h1, pulse_cnt: quasi_ports_pkg::CNT_ZERO, pin_o: 1'h1,
             pin_oe: 1'h0, weak_pu: 1'h1, sync_a: 1'h1, sync_b: 1'h1};
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign o_pin_o = q.pin_o;
  assign o_pin_oe = q.pin_oe;
  assign o_weak_pu = q.weak_pu;
  assign o_pin_sync = q.sync_b;
  assign o_latch = q.latch;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  low_drive_a: assert property (!q.eff |-> q.pin_oe && !q.pin_o && !q.weak_pu)
    else $error("zero level not strongly pulled down");

  pulse_start_a: assert property ($rose(q.eff) |-> q.pin_oe && q.pin_o ##1 (!q.eff || q.pin_oe))
    else $error("strong pull-high pulse too short");

  pulse_end_a: assert property ($rose(q.eff) ##1 q.eff ##1 q.eff |-> !q.pin_oe && q.weak_pu)
    else $error("strong pull-high pulse did not end");

  latch_keep_a: assert property (!i_latch_wr |=> q.latch == $past(q.latch))
    else $error("port latch changed without a write");

endmodule

// ---- dv/pin_partner.sv ----
// board side of one port: pullup wires with an optional external pull low
module pin_partner (
  input wire logic [7:0] i_o,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_low,
  output logic [7:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // strong drive wins; otherwise the board may overcome the weak pullup
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      o_pin[b] = i_oe[b] ? i_o[b] : ~i_low[b];
    end
  end
endmodule

// ---- dv/quasi_bidir_ports_one_two_tb_top.sv ----
// self-checking bench for the two quasi-bidirectional ports
module quasi_bidir_ports_one_two_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_first_port_wr = 1'b0, i_second_port_wr = 1'b0;
  logic [7:0] i_first_port_wdata = 8'h00, i_second_port_wdata = 8'hff, low = 8'h00, acc;
  logic [7:0] low2 = 8'h00;
  logic [7:0] i_first_port_pins, i_second_port_pins, o_first_port_pins_o, o_first_port_pins_oe;
  logic [7:0] o_first_port_weak_pu, o_second_port_pins_o, o_second_port_pins_oe, o_ext_rdata;
  logic [7:0] o_second_port_weak_pu, o_first_port_rd, o_second_port_rd;
  logic [7:0] o_first_port_latch, o_second_port_latch;
  logic i_timer_two_ext_io_en = 1'b0, i_timer_two_ext_io_out = 1'b1, i_second_serial_tx_en = 1'b0;
  logic i_second_serial_transmit = 1'b1, o_timer_two_ext_io_in, o_timer_two_capture_trigger;
  logic o_second_serial_receive, o_ext_irq_rise_a, o_ext_irq_fall_a, o_ext_irq_rise_b;
  logic o_ext_irq_fall_b, o_ale;
  logic [3:0] seen = 4'h0;
  int mismatches = 0, total_checks = 0, ticks = 0;
  quasi_ports_pkg::ext_bus_s i_ext_bus = '0;
  quasi_bidir_ports_one_two dut (.i_sys_clk, .i_rst_b, .i_first_port_wr, .i_first_port_wdata,
    .i_second_port_wr, .i_second_port_wdata, .i_first_port_pins, .o_first_port_pins_o,
    .o_first_port_pins_oe, .o_first_port_weak_pu, .i_second_port_pins, .o_second_port_pins_o,
    .o_second_port_pins_oe, .o_second_port_weak_pu, .o_first_port_rd, .o_second_port_rd,
    .o_first_port_latch, .o_second_port_latch, .i_timer_two_ext_io_en, .i_timer_two_ext_io_out,
    .o_timer_two_ext_io_in, .o_timer_two_capture_trigger, .i_second_serial_tx_en,
    .i_second_serial_transmit, .o_second_serial_receive, .o_ext_irq_rise_a, .o_ext_irq_fall_a,
    .o_ext_irq_rise_b, .o_ext_irq_fall_b, .i_ext_bus, .o_ext_rdata, .o_ale);
  pin_partner p1 (.i_o(o_first_port_pins_o), .i_oe(o_first_port_pins_oe), .i_low(low),
    .o_pin(i_first_port_pins));
  pin_partner p2 (.i_o(o_second_port_pins_o), .i_oe(o_second_port_pins_oe), .i_low(low2),
    .o_pin(i_second_port_pins));
  initial begin
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // interrupt strobes last one cycle, so they are collected sticky
  always @(posedge i_sys_clk) begin
    seen <= seen | {o_ext_irq_fall_b, o_ext_irq_rise_b, o_ext_irq_fall_a, o_ext_irq_rise_a};
    ticks <= ticks + 1;
    if (ticks == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic chk(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask
  task automatic wr1(input logic [7:0] v);
    i_first_port_wdata = v;
    i_first_port_wr = 1'b1;
    cyc(1);
    i_first_port_wr = 1'b0;
  endtask
  task automatic t_reset();
    chk("latch1", o_first_port_latch, 8'hff);
    chk("pu1", o_first_port_weak_pu, 8'hff);
    chk("latch2", o_second_port_latch, 8'hff);
    chk("oe2", o_second_port_pins_oe, 8'h00);
  endtask
  task automatic t_zero_one();
    wr1(8'h00);
    cyc(4);
    chk("pins low", i_first_port_pins, 8'h00);
    chk("oe low", o_first_port_pins_oe, 8'hff);
    wr1(8'hff);
    acc = 8'h00;
    // pulse width is short, so accumulate over a window
    repeat (4) begin
      acc = acc | (o_first_port_pins_oe & o_first_port_pins_o);
      cyc(1);
    end
    chk("pulse", acc, 8'hff);
    chk("oe off", o_first_port_pins_oe, 8'h00);
    chk("pu on", o_first_port_weak_pu, 8'hff);
  endtask
  task automatic t_alt();
    seen = 4'h0;
    low = 8'hf6;
    cyc(6);
    chk("rd", o_first_port_rd, 8'h09);
    chk("trig", {7'h00, o_timer_two_capture_trigger}, 8'h00);
    chk("t2 in", {7'h00, o_timer_two_ext_io_in}, 8'h01);
    chk("rx", {7'h00, o_second_serial_receive}, 8'h00);
    chk("falls", {6'h00, seen[3], seen[1]}, 8'h03);
    seen = 4'h0;
    low = 8'h00;
    i_second_serial_tx_en = 1'b1;
    i_second_serial_transmit = 1'b0;
    cyc(6);
    chk("trig hi", {7'h00, o_timer_two_capture_trigger}, 8'h01);
    chk("rises", {6'h00, seen[2], seen[0]}, 8'h03);
    chk("tx pin", {7'h00, i_first_port_pins[3]}, 8'h00);
    i_second_serial_tx_en = 1'b0;
  endtask
  task automatic t_bus();
    i_ext_bus.addr = 16'ha55a;
    i_ext_bus.cycle = 1'b1;
    i_ext_bus.addr_strobe = 1'b1;
    cyc(3);
    chk("addr hi", i_second_port_pins, 8'ha5);
    chk("ale", {7'h00, o_ale}, 8'h01);
    i_ext_bus.addr_strobe = 1'b0;
    i_ext_bus.mode = quasi_ports_pkg::MODE_PAGE_ONE;
    cyc(3);
    chk("addr lo", i_second_port_pins, 8'h5a);
    chk("ale off", {7'h00, o_ale}, 8'h00);
    i_ext_bus.mode = quasi_ports_pkg::MODE_PAGE_TWO;
    i_ext_bus.write = 1'b1;
    i_ext_bus.wdata = 8'h3c;
    cyc(4);
    chk("data", i_second_port_pins, 8'h3c);
    chk("rd2", o_second_port_rd, 8'h3c);
    // read phase: port released, board drives the byte against the pullups
    i_ext_bus.write = 1'b0;
    low2 = 8'h96;
    cyc(6);
    chk("rdata", o_ext_rdata, 8'h69);
    low2 = 8'h00;
    i_ext_bus = '0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    i_rst_b = 1'b1;
    cyc(2);
    t_reset();
    t_zero_one();
    t_alt();
    t_bus();
    stop_test();
  end
endmodule
